// File: bst_regs.svh
`ifndef BST_REGS_SVH
`define BST_REGS_SVH

`define BST_IR_W         8
`define BST_IR_CAPTURE   8'h01
`define BST_INS_EXTEST   8'h00
`define BST_INS_IDCODE   8'h01
`define BST_INS_SAMPLE   8'h02
`define BST_INS_CLAMP    8'h03
`define BST_INS_HIGHZ    8'h04
`define BST_INS_BYPASS   8'hFF
`define BST_ID_W         32
// arbitrary neutral value, bit 0 marks a present identification register
`define BST_IDCODE_VAL   32'h1000_0001
`define BST_BSR_LEN      113

`endif

// File: bst_pkg.sv
`default_nettype none

package bst_pkg;

    typedef enum logic [3:0]
    {
        ST_RESET,
        ST_IDLE,
        ST_SEL_DR,
        ST_CAP_DR,
        ST_SH_DR,
        ST_EX1_DR,
        ST_PAU_DR,
        ST_EX2_DR,
        ST_UPD_DR,
        ST_SEL_IR,
        ST_CAP_IR,
        ST_SH_IR,
        ST_EX1_IR,
        ST_PAU_IR,
        ST_EX2_IR,
        ST_UPD_IR
    } bst_state_t;

    typedef enum logic [1:0]
    {
        SEL_BYPASS,
        SEL_BSR,
        SEL_ID
    } bst_dr_sel_t;

endpackage

`default_nettype wire

// File: bst_tap.sv
`include "bst_regs.svh"
`default_nettype none

module bst_tap
#(
    parameter int BSR_LEN = `BST_BSR_LEN
)
(
    input  wire logic               ref_clk_i,
    input  wire logic               rst_i,
    input  wire logic               tck_i,
    input  wire logic               tms_i,
    input  wire logic               tdi_i,
    input  wire logic [BSR_LEN-1:0] bsr_pin_i,
    output var  logic               tdo_o,
    output var  logic               tdo_oe_o,
    output var  logic [BSR_LEN-1:0] bsr_out_o,
    output var  logic               bsr_drive_o,
    output var  logic               outputs_highz_o,
    output var  logic               test_reset_o
);

    generate
        if (BSR_LEN < 2)
        begin : g_bad_len
            $error("bst_tap: BSR_LEN must be at least 2");
        end
    endgenerate

    logic                  tck_s1_ff;
    logic                  tck_s2_ff;
    logic                  tck_d_ff;
    logic                  tms_s1_ff;
    logic                  tms_s2_ff;
    logic                  tdi_s1_ff;
    logic                  tdi_s2_ff;
    logic [BSR_LEN-1:0]    pin_s1_ff;
    logic [BSR_LEN-1:0]    pin_s2_ff;

    bst_pkg::bst_state_t   state_ff;
    bst_pkg::bst_state_t   nxt_state;
    logic [`BST_IR_W-1:0]  ir_ff;
    logic [`BST_IR_W-1:0]  ir_sh_ff;
    logic [BSR_LEN-1:0]    bsr_sh_ff;
    logic [`BST_ID_W-1:0]  id_sh_ff;
    logic                  byp_ff;
    logic                  tck_rise;
    logic                  tck_fall;
    bst_pkg::bst_dr_sel_t  dr_sel;
    logic                  scan_bit;

    // next state from the sampled TMS level
    function automatic bst_pkg::bst_state_t tap_next(
        input bst_pkg::bst_state_t st,
        input logic                tms
    );
        bst_pkg::bst_state_t nx;
        nx = bst_pkg::ST_RESET;
        case (st)
            bst_pkg::ST_RESET:
                nx = tms ? bst_pkg::ST_RESET : bst_pkg::ST_IDLE;
            bst_pkg::ST_IDLE:
                nx = tms ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
            bst_pkg::ST_SEL_DR:
                nx = tms ? bst_pkg::ST_SEL_IR : bst_pkg::ST_CAP_DR;
            bst_pkg::ST_CAP_DR:
                nx = tms ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SH_DR;
            bst_pkg::ST_SH_DR:
                nx = tms ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SH_DR;
            bst_pkg::ST_EX1_DR:
                nx = tms ? bst_pkg::ST_UPD_DR : bst_pkg::ST_PAU_DR;
            bst_pkg::ST_PAU_DR:
                nx = tms ? bst_pkg::ST_EX2_DR : bst_pkg::ST_PAU_DR;
            bst_pkg::ST_EX2_DR:
                nx = tms ? bst_pkg::ST_UPD_DR : bst_pkg::ST_SH_DR;
            bst_pkg::ST_UPD_DR:
                nx = tms ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
            bst_pkg::ST_SEL_IR:
                nx = tms ? bst_pkg::ST_RESET : bst_pkg::ST_CAP_IR;
            bst_pkg::ST_CAP_IR:
                nx = tms ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SH_IR;
            bst_pkg::ST_SH_IR:
                nx = tms ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SH_IR;
            bst_pkg::ST_EX1_IR:
                nx = tms ? bst_pkg::ST_UPD_IR : bst_pkg::ST_PAU_IR;
            bst_pkg::ST_PAU_IR:
                nx = tms ? bst_pkg::ST_EX2_IR : bst_pkg::ST_PAU_IR;
            bst_pkg::ST_EX2_IR:
                nx = tms ? bst_pkg::ST_UPD_IR : bst_pkg::ST_SH_IR;
            bst_pkg::ST_UPD_IR:
                nx = tms ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
            default:
                nx = bst_pkg::ST_RESET;
        endcase
        return nx;
    endfunction

    // data register chosen by the held instruction
    function automatic bst_pkg::bst_dr_sel_t dr_pick(
        input logic [`BST_IR_W-1:0] ins
    );
        bst_pkg::bst_dr_sel_t s;
        s = bst_pkg::SEL_BYPASS;
        if (ins == `BST_INS_EXTEST || ins == `BST_INS_SAMPLE)
        begin
            s = bst_pkg::SEL_BSR;
        end
        else if (ins == `BST_INS_IDCODE)
        begin
            s = bst_pkg::SEL_ID;
        end
        else
        begin
            s = bst_pkg::SEL_BYPASS;
        end
        return s;
    endfunction

    // all pins come from outside this clock's domain
    // reset values of one make an idle port look pulled high
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            tck_s1_ff <= 1'b0;
            tck_s2_ff <= 1'b0;
            tck_d_ff  <= 1'b0;
            tms_s1_ff <= 1'b1;
            tms_s2_ff <= 1'b1;
            tdi_s1_ff <= 1'b1;
            tdi_s2_ff <= 1'b1;
        end
        else
        begin
            tck_s1_ff <= tck_i;
            tck_s2_ff <= tck_s1_ff;
            tck_d_ff  <= tck_s2_ff;
            tms_s1_ff <= tms_i;
            tms_s2_ff <= tms_s1_ff;
            tdi_s1_ff <= tdi_i;
            tdi_s2_ff <= tdi_s1_ff;
        end
    end

    // pin levels may move at any time; capture may see either value
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            pin_s1_ff <= '0;
            pin_s2_ff <= '0;
        end
        else
        begin
            pin_s1_ff <= bsr_pin_i;
            pin_s2_ff <= pin_s1_ff;
        end
    end

    assign tck_rise = tck_s2_ff & ~tck_d_ff;
    assign tck_fall = ~tck_s2_ff & tck_d_ff;
    assign nxt_state = tap_next(state_ff, tms_s2_ff);
    assign dr_sel = dr_pick(ir_ff);

    // a held-low test clock never advances this
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            state_ff <= bst_pkg::ST_RESET;
        end
        else if (tck_rise)
        begin
            state_ff <= nxt_state;
        end
    end

    // instruction shift path
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            ir_sh_ff <= `BST_IR_CAPTURE;
        end
        else if (tck_rise)
        begin
            if (state_ff == bst_pkg::ST_CAP_IR)
            begin
                ir_sh_ff <= `BST_IR_CAPTURE;
            end
            else if (state_ff == bst_pkg::ST_SH_IR)
            begin
                ir_sh_ff <= {tdi_s2_ff, ir_sh_ff[`BST_IR_W-1:1]};
            end
        end
    end

    // held instruction; changes on the falling edge inside update-IR, and is forced to IDCODE while in the reset state
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            ir_ff <= `BST_INS_IDCODE;
        end
        else if (state_ff == bst_pkg::ST_RESET)
        begin
            ir_ff <= `BST_INS_IDCODE;
        end
        else if (tck_fall && state_ff == bst_pkg::ST_UPD_IR)
        begin
            ir_ff <= ir_sh_ff;
        end
    end

    // boundary shift cells; select-DR and pause leave them alone
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            bsr_sh_ff <= '0;
        end
        else if (tck_rise && dr_sel == bst_pkg::SEL_BSR)
        begin
            if (state_ff == bst_pkg::ST_CAP_DR)
            begin
                bsr_sh_ff <= pin_s2_ff;
            end
            else if (state_ff == bst_pkg::ST_SH_DR)
            begin
                bsr_sh_ff <= {tdi_s2_ff, bsr_sh_ff[BSR_LEN-1:1]};
            end
        end
    end

    // identification shift cells
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            id_sh_ff <= `BST_IDCODE_VAL;
        end
        else if (tck_rise && dr_sel == bst_pkg::SEL_ID)
        begin
            if (state_ff == bst_pkg::ST_CAP_DR)
            begin
                id_sh_ff <= `BST_IDCODE_VAL;
            end
            else if (state_ff == bst_pkg::ST_SH_DR)
            begin
                id_sh_ff <= {tdi_s2_ff, id_sh_ff[`BST_ID_W-1:1]};
            end
        end
    end

    // bypass cell captures zero, then gives one bit of delay
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            byp_ff <= 1'b0;
        end
        else if (tck_rise && dr_sel == bst_pkg::SEL_BYPASS)
        begin
            if (state_ff == bst_pkg::ST_CAP_DR)
            begin
                byp_ff <= 1'b0;
            end
            else if (state_ff == bst_pkg::ST_SH_DR)
            begin
                byp_ff <= tdi_s2_ff;
            end
        end
    end

    // parallel output latch, written only in update-DR
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            bsr_out_o <= '0;
        end
        else if (tck_fall && state_ff == bst_pkg::ST_UPD_DR && dr_sel == bst_pkg::SEL_BSR)
        begin
            bsr_out_o <= bsr_sh_ff;
        end
    end

    // output steering from the held instruction; quiet in reset state
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            bsr_drive_o     <= 1'b0;
            outputs_highz_o <= 1'b0;
            test_reset_o    <= 1'b1;
        end
        else
        begin
            bsr_drive_o     <= (ir_ff == `BST_INS_EXTEST || ir_ff == `BST_INS_CLAMP)
                               && state_ff != bst_pkg::ST_RESET;
            outputs_highz_o <= (ir_ff == `BST_INS_HIGHZ) && state_ff != bst_pkg::ST_RESET;
            test_reset_o    <= (state_ff == bst_pkg::ST_RESET);
        end
    end

    // serial bit at the low end of whichever register is in the path
    always_comb
    begin
        scan_bit = byp_ff;
        if (state_ff == bst_pkg::ST_SH_IR)
        begin
            scan_bit = ir_sh_ff[0];
        end
        else if (dr_sel == bst_pkg::SEL_BSR)
        begin
            scan_bit = bsr_sh_ff[0];
        end
        else if (dr_sel == bst_pkg::SEL_ID)
        begin
            scan_bit = id_sh_ff[0];
        end
        else
        begin
            scan_bit = byp_ff;
        end
    end

    // launched on the falling edge so the tester can sample at the next rise
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            tdo_o    <= 1'b0;
            tdo_oe_o <= 1'b0;
        end
        else if (tck_fall)
        begin
            tdo_o    <= scan_bit;
            tdo_oe_o <= (state_ff == bst_pkg::ST_SH_IR)
                        || (state_ff == bst_pkg::ST_SH_DR);
        end
    end

endmodule // bst_tap

`default_nettype wire

// File: bst_jtag_host.sv
`default_nettype none

module bst_jtag_host
(
    input  wire logic clk_i,
    input  wire logic tdo_i,
    input  wire logic tdo_oe_i,
    output var  logic tck_o,
    output var  logic tms_o,
    output var  logic tdi_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // memory-side lines parked by the tester; the test clock only runs while they stay parked
    logic impedance_output_select_bit;
    logic mem_chip_sel_n;

    // parked: clock low, select and data at their pulled-up level
    initial
    begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b1;
        impedance_output_select_bit = 1'b0;
        mem_chip_sel_n = 1'b1;
    end

    // one 400 ns test-clock period; tdo is read just before the next fall
    task automatic bit_io(input logic tms, input logic tdi, output logic tdo_v, output logic oe_v);
        @(posedge clk_i);
        #1;
        tck_o = 1'b0;
        tms_o = tms;
        tdi_o = tdi;
        repeat (4) @(posedge clk_i);
        #1 tck_o = mem_chip_sel_n & ~impedance_output_select_bit;
        repeat (3) @(posedge clk_i);
        oe_v = tdo_oe_i;
        // a released line reads back inverted, so a missing enable cannot hide
        tdo_v = tdo_oe_i ? tdo_i : ~tdo_i;
    endtask
endmodule // bst_jtag_host

`default_nettype wire

// File: bst_tap_sva.sv
`default_nettype none

module bst_tap_sva
#(
    parameter int BSR_LEN = 8
)
(
    input wire logic               ref_clk_i,
    input wire logic               rst_i,
    input wire logic               tck_i,
    input wire logic               tms_i,
    input wire logic               tdo_o,
    input wire logic               tdo_oe_o,
    input wire logic [BSR_LEN-1:0] bsr_out_o,
    input wire logic               bsr_drive_o,
    input wire logic               outputs_highz_o,
    input wire logic               test_reset_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic       tck_ff;
    logic [2:0] ones_ff;

    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    always_ff @(posedge ref_clk_i)
    begin
        tck_ff <= tck_i;
    end

    // rises seen with tms high in a row, saturating
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            ones_ff <= 3'h0;
        else if (tck_i && !tck_ff)
            ones_ff <= !tms_i ? 3'h0 : ((ones_ff == 3'h7) ? ones_ff : ones_ff + 3'h1);
    end

    a_rst_state: assert property ($fell(rst_i) |-> test_reset_o && !tdo_oe_o && bsr_out_o == '0)
        else $error("port not idle after reset");
    a_tdo_edge: assert property ($changed(tdo_o) |-> !$past(tck_i) && !$past(tck_i, 2))
        else $error("tdo moved outside a clock fall");
    a_oe_edge: assert property ($changed(tdo_oe_o) |-> !$past(tck_i) && !$past(tck_i, 2))
        else $error("tdo enable moved outside a clock fall");
    a_bsr_edge: assert property ($changed(bsr_out_o) |-> !$past(tck_i) && !test_reset_o)
        else $error("boundary outputs moved off update");
    a_oe_hold: assert property ($changed(tdo_oe_o) |=> $stable(tdo_oe_o)[*6])
        else $error("tdo enable glitch");
    a_tdo_hold: assert property ($changed(tdo_o) |=> $stable(tdo_o)[*6])
        else $error("tdo glitch");
    a_mode_excl: assert property (!(bsr_drive_o && outputs_highz_o))
        else $error("clamp and float together");
    a_reset_quiet: assert property ($past(test_reset_o, 3) && test_reset_o |-> !bsr_drive_o && !outputs_highz_o
        && !tdo_oe_o)
        else $error("test logic active in reset");
    a_five_ones: assert property ($rose(ones_ff >= 3'h5) |-> ##[1:8] test_reset_o)
        else $error("five high selects missed reset");
    a_reset_hold: assert property (test_reset_o && tms_i && $past(tms_i) |=> test_reset_o)
        else $error("left reset with select high");
endmodule // bst_tap_sva

`default_nettype wire

// File: boundary_scan_tap_test.sv
`include "bst_regs.svh"
`default_nettype none

module boundary_scan_tap_test;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int BSR_LEN = 8;

    typedef struct {
        logic [7:0]  ins;
        int          len;
        logic [31:0] cap;
        logic        drive;
        logic        highz;
        logic        upd;
    } bst_row_t;

    bst_row_t rows [7] = '{
        '{`BST_INS_IDCODE, 32, `BST_IDCODE_VAL, 1'b0, 1'b0, 1'b0},
        '{`BST_INS_BYPASS, 1, 32'h0, 1'b0, 1'b0, 1'b0},
        '{`BST_INS_HIGHZ, 1, 32'h0, 1'b0, 1'b1, 1'b0},
        '{`BST_INS_CLAMP, 1, 32'h0, 1'b1, 1'b0, 1'b0},
        '{8'h5A, 1, 32'h0, 1'b0, 1'b0, 1'b0},
        '{`BST_INS_SAMPLE, 8, 32'hC5, 1'b0, 1'b0, 1'b1},
        '{`BST_INS_EXTEST, 8, 32'h3A, 1'b1, 1'b0, 1'b1}
    };

    logic               ref_clk;
    logic               rst;
    logic               tck;
    logic               tms;
    logic               tdi;
    logic               tdo;
    logic               tdo_oe;
    logic               drive;
    logic               highz;
    logic               treset;
    logic               oe_v;
    logic [BSR_LEN-1:0] pins;
    logic [BSR_LEN-1:0] bsr_out;
    logic [BSR_LEN-1:0] bsr_exp;
    logic [39:0]        din;
    logic [39:0]        dout;
    logic [39:0]        exp_v;
    int                 n_mismatch;
    int                 n_tests;

    bst_tap #(.BSR_LEN(BSR_LEN)) u_dut (.ref_clk_i(ref_clk), .rst_i(rst), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
        .bsr_pin_i(pins), .tdo_o(tdo), .tdo_oe_o(tdo_oe), .bsr_out_o(bsr_out), .bsr_drive_o(drive),
        .outputs_highz_o(highz), .test_reset_o(treset));

    bst_jtag_host u_host (.clk_i(ref_clk), .tdo_i(tdo), .tdo_oe_i(tdo_oe), .tck_o(tck), .tms_o(tms), .tdi_o(tdi));

    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    task automatic check(input string what, input logic [39:0] seen, input logic [39:0] want);
        n_tests++;
        if (seen !== want)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %0h seen %0h", what, want, seen);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic step(input logic tms_v, output logic oe);
        logic t;
        u_host.bit_io(tms_v, 1'b1, t, oe);
    endtask

    // idle, scan, idle; after bit p the shift is parked in pause
    task automatic scan(input logic ir, input int n, input int p, input logic [39:0] d, output logic [39:0] q);
        logic o;
        q = '0;
        step(1'b1, o);
        if (ir)
            step(1'b1, o);
        step(1'b0, o);
        step(1'b0, o);
        for (int i = 0; i < n; i++)
        begin
            u_host.bit_io(i == n - 1 || i == p, d[i], q[i], o);
            check("tdo_oe shift", o, 1'b1);
            if (i == p)
            begin
                step(1'b0, o);
                step(1'b0, o);
                check("tdo_oe pause", o, 1'b0);
                step(1'b1, o);
                step(1'b0, o);
            end
        end
        step(1'b1, o);
        check("tdo_oe exit", o, 1'b0);
        step(1'b0, o);
    endtask

    initial
    begin
        #1ms;
        n_mismatch++;
        stop_test();
    end

    initial
    begin
        n_mismatch = 0;
        n_tests = 0;
        rst = 1'b1;
        pins = '0;
        bsr_exp = '0;
        repeat (8) @(posedge ref_clk);
        #1 rst = 1'b0;
        @(posedge ref_clk);
        #1;
        check("test_reset", treset, 1'b1);
        check("tdo_oe", tdo_oe, 1'b0);
        // scan begins only once a lone mode set would have recovered
        repeat (6) @(posedge ref_clk);
        step(1'b0, oe_v);
        foreach (rows[r])
        begin
            #1 pins = rows[r].cap[BSR_LEN-1:0];
            scan(1'b1, 8, 99, {32'h0, rows[r].ins}, dout);
            check("ir capture", dout[7:0], `BST_IR_CAPTURE);
            check("drive", drive, rows[r].drive);
            check("highz", highz, rows[r].highz);
            din = 40'h965A3CC3A5 ^ 40'(r);
            scan(1'b0, rows[r].len + 4, 99, din, dout);
            exp_v = ((din << rows[r].len) | rows[r].cap) & ((40'h1 << (rows[r].len + 4)) - 40'h1);
            check("dr out", dout, exp_v);
            if (rows[r].upd)
                bsr_exp = din[BSR_LEN+3:4];
            check("bsr_out", bsr_out, bsr_exp);
            $display("row %0d done", r);
        end
        // from shift-DR; treset lags one step, so each check sees the select count before its own
        step(1'b1, oe_v);
        step(1'b0, oe_v);
        step(1'b0, oe_v);
        for (int k = 0; k < 5; k++)
        begin
            step(1'b1, oe_v);
            check("early reset", treset, 1'b0);
        end
        step(1'b1, oe_v);
        check("test_reset", treset, 1'b1);
        check("drive", drive, 1'b0);
        check("tdo_oe", oe_v, 1'b0);
        repeat (3) step(1'b0, oe_v);
        scan(1'b0, 32, 9, 40'h0, dout);
        check("id after reset", dout[31:0], `BST_IDCODE_VAL);
        $display("reset and pause test done");
        stop_test();
    end
endmodule // boundary_scan_tap_test

bind bst_tap bst_tap_sva #(.BSR_LEN(BSR_LEN)) u_sva (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .tck_i(tck_i),
    .tms_i(tms_i), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .bsr_out_o(bsr_out_o), .bsr_drive_o(bsr_drive_o),
    .outputs_highz_o(outputs_highz_o), .test_reset_o(test_reset_o));

`default_nettype wire
